//--- logic/eict_capture_timer.v
// Three-channel input capture timer with compare, reload and register port.
//==========================================================
// Function
// - Three capture channels, each with its own hold register.
// - With filter on, edge accepted after four equal new samples.
// - Filter bypass bit routes inputs straight to edge detectors.
// - Per-channel source select: pin, comparator or converter compare.
// - Two-bit edge select per channel: rising, falling or both.
// - Main control bits 6:4 enable channels 0 to 2.
// - Status bits 10:8 show current channel input levels.
// - Divider divides by 1,4,16,32,64,96,112 or 128.
// - Divider source: system clock, dedicated clock or channel input.
// - Unit enable must be set; counting, capture, compare and reload idle while clear.
// - Capture copies counter into hold register; counter keeps running.
// - Capture sets channel flag; interrupt when its enable set.
// - Flags set by hardware, cleared by writing one; zero no effect.
// - Clear-on-capture resets counter to zero on capture.
// - Compare match sets match flag; interrupt if enabled.
// - Clear-on-match clears counter after match.
// - Reload loads compare value on overflow or selected capture of channel 0 or 1.
// - Clear-on-capture with reload: capture performs only reload.
// - Interrupt is OR of five enabled flags.
// - Hold register n takes counter captured by channel n.
`timescale 1ns/10ps
`default_nettype none
`include "eict_defines.vh"
module eict_capture_timer #(
   parameter CW = 24,
   parameter NCH = 3
) (
   input wire ref_clk,
   input wire resetn,
   input wire [7:0] regAddr,
   input wire [31:0] regWdata,
   input wire regWr,
   input wire regRd,
   output reg [31:0] regRdata_q,
   input wire [NCH-1:0] capturePin,
   input wire [NCH-1:0] comparatorCaptureSource,
   input wire converterCompareSource,
   input wire dedicatedCounterClock,
   output reg unitInterrupt_q,
   output reg matchInterrupt_q,
   output reg wrapInterrupt_q
);
   //==========================================================
   // Registers
   reg [CW-1:0] count_q;
   reg [CW-1:0] hold_q [0:NCH-1];
   reg [CW-1:0] cmpVal_q;
   reg [31:0] ctl0_q;
   reg [31:0] ctl1_q;
   reg [NCH-1:0] capFlag_q;
   reg matchFlag_q;
   reg ovfFlag_q;
   reg matchPrev_q;
   wire [NCH-1:0] level;
   wire [NCH-1:0] edgeHit;
   wire [NCH-1:0] capEvent;
   wire unitEn;
   wire tick;
   wire wrCnt;
   wire wrSts;
   wire wrap;
   wire match;
   wire matchEvt;
   wire capAny;
   wire reloadTrig;
   reg [NCH-1:0] srcMux;
   reg divChan;
   reg [31:0] rdMux;
   integer i;
   integer j;

   assign unitEn = ctl0_q[`EICT_C0_UNITEN];

   //==========================================================
   // Channel front ends
   always @* begin
      for (i = 0; i < NCH; i = i + 1) begin
         case (ctl0_q[`EICT_C0_SRC_LO + 2*i +: 2])
            2'h0: srcMux[i] = capturePin[i];
            2'h1: srcMux[i] = comparatorCaptureSource[i];
            default: srcMux[i] = converterCompareSource;
         endcase
      end
   end

   genvar g;
   generate
      for (g = 0; g < NCH; g = g + 1) begin : gChan
         eict_filter uFilt (
            .ref_clk(ref_clk),
            .resetn(resetn),
            .sampleIn(srcMux[g]),
            .bypass(ctl0_q[`EICT_C0_BYPASS]),
            .edgeSel(ctl1_q[`EICT_C1_EDGE_LO + 2*g +: 2]),
            .level_q(level[g]),
            .edgeHit(edgeHit[g])
         );
         // Capture only while the unit and the channel are enabled.
         assign capEvent[g] = edgeHit[g] & unitEn & ctl0_q[`EICT_C0_CHEN_LO + g];
      end
   endgenerate

   //==========================================================
   // Counter clock
   always @* begin
      case (ctl1_q[`EICT_C1_CSRC_LO +: 2])
         2'h2: divChan = level[1];
         2'h3: divChan = level[2];
         default: divChan = level[0];
      endcase
   end

   eict_divider uDiv (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .srcSel(ctl1_q[`EICT_C1_CSRC_LO +: 2]),
      .divSel(ctl1_q[`EICT_C1_DIV_LO +: 3]),
      .dedicatedIn(dedicatedCounterClock),
      .chanIn(divChan),
      .runEn(ctl0_q[`EICT_C0_RUN] & unitEn),
      .tick(tick)
   );

   //==========================================================
   // Counter operation
   assign wrCnt = regWr && (regAddr == `EICT_ADDR_CNT);
   assign wrSts = regWr && (regAddr == `EICT_ADDR_STS);
   assign wrap = tick && (&count_q);
   assign match = unitEn && ctl0_q[`EICT_C0_COMPARE_ENABLE] && (count_q == cmpVal_q);
   // Flag a match once on entry so a stopped counter does not re-fire.
   assign matchEvt = match && !matchPrev_q;
   assign capAny = |capEvent;
   assign reloadTrig = unitEn && ctl0_q[`EICT_C0_RELOAD_ENABLE] &&
      ((ctl1_q[`EICT_C1_RLDS_LO] && wrap) ||
       (ctl1_q[`EICT_C1_RLDS_LO + 1] && capEvent[0]) ||
       (ctl1_q[`EICT_C1_RLDS_LO + 2] && capEvent[1]) ||
       (ctl1_q[`EICT_C1_RLDS_LO + 3] && capEvent[2]));

   always @(posedge ref_clk) begin
      if (!resetn) begin
         count_q <= {CW{1'b0}};
         matchPrev_q <= 1'b0;
      end else begin
         matchPrev_q <= match;
         if (reloadTrig)
            count_q <= cmpVal_q;
         else if (capAny && ctl0_q[`EICT_C0_CLRCAP] && !ctl0_q[`EICT_C0_RELOAD_ENABLE])
            count_q <= {CW{1'b0}};
         else if (matchEvt && ctl0_q[`EICT_C0_CLRCMP])
            count_q <= {CW{1'b0}};
         else if (wrCnt)
            count_q <= regWdata[CW-1:0];
         else if (tick)
            count_q <= count_q + {{(CW-1){1'b0}}, 1'b1};
      end
   end

   //==========================================================
   // Hold registers
   always @(posedge ref_clk) begin
      if (!resetn) begin
         for (j = 0; j < NCH; j = j + 1)
            hold_q[j] <= (j == 2) ? `EICT_HLD2_RESET : {CW{1'b0}};
      end else begin
         for (j = 0; j < NCH; j = j + 1) begin
            if (capEvent[j])
               hold_q[j] <= count_q;
            else if (regWr && (regAddr == `EICT_ADDR_HLD0 + 8'h04 * j[7:0]))
               hold_q[j] <= regWdata[CW-1:0];
         end
      end
   end

   //==========================================================
   // Control registers
   always @(posedge ref_clk) begin
      if (!resetn) begin
         cmpVal_q <= {CW{1'b0}};
         ctl0_q <= 32'h0000_0000;
         ctl1_q <= 32'h0000_0000;
      end else if (regWr) begin
         if (regAddr == `EICT_ADDR_CMP)
            cmpVal_q <= regWdata[CW-1:0];
         if (regAddr == `EICT_ADDR_CTL0)
            ctl0_q <= regWdata & `EICT_C0_MASK;
         if (regAddr == `EICT_ADDR_CTL1)
            ctl1_q <= regWdata & `EICT_C1_MASK;
      end
   end

   //==========================================================
   // Flags: a set in the same cycle as a clear wins.
   always @(posedge ref_clk) begin
      if (!resetn) begin
         capFlag_q <= {NCH{1'b0}};
         matchFlag_q <= 1'b0;
         ovfFlag_q <= 1'b0;
      end else begin
         capFlag_q <= (capFlag_q & ~({NCH{wrSts}} & regWdata[`EICT_ST_CAPF_LO +: NCH]))
                      | capEvent;
         matchFlag_q <= (matchFlag_q & ~(wrSts & regWdata[`EICT_ST_CMPF])) | matchEvt;
         ovfFlag_q <= (ovfFlag_q & ~(wrSts & regWdata[`EICT_ST_OVF])) | wrap;
      end
   end

   //==========================================================
   // Interrupt outputs
   always @(posedge ref_clk) begin
      if (!resetn) begin
         unitInterrupt_q <= 1'b0;
         matchInterrupt_q <= 1'b0;
         wrapInterrupt_q <= 1'b0;
      end else begin
         matchInterrupt_q <= matchFlag_q & ctl0_q[`EICT_C0_CMPIE];
         wrapInterrupt_q <= ovfFlag_q & ctl0_q[`EICT_C0_OVIE];
         unitInterrupt_q <= |(capFlag_q & ctl0_q[`EICT_C0_CAPIE_LO +: NCH])
                            | (matchFlag_q & ctl0_q[`EICT_C0_CMPIE])
                            | (ovfFlag_q & ctl0_q[`EICT_C0_OVIE]);
      end
   end

   //==========================================================
   // Read port
   always @* begin
      rdMux = 32'h0000_0000;
      case (regAddr)
         `EICT_ADDR_CNT: rdMux[CW-1:0] = count_q;
         `EICT_ADDR_HLD0: rdMux[CW-1:0] = hold_q[0];
         `EICT_ADDR_HLD1: rdMux[CW-1:0] = hold_q[1];
         `EICT_ADDR_HLD2: rdMux[CW-1:0] = hold_q[2];
         `EICT_ADDR_CMP: rdMux[CW-1:0] = cmpVal_q;
         `EICT_ADDR_CTL0: rdMux = ctl0_q;
         `EICT_ADDR_CTL1: rdMux = ctl1_q;
         `EICT_ADDR_STS: begin
            rdMux[`EICT_ST_CAPF_LO +: NCH] = capFlag_q;
            rdMux[`EICT_ST_CMPF] = matchFlag_q;
            rdMux[`EICT_ST_OVF] = ovfFlag_q;
            rdMux[`EICT_ST_LVL_LO +: NCH] = level;
         end
         default: rdMux = 32'h0000_0000;
      endcase
   end

   always @(posedge ref_clk) begin
      if (!resetn)
         regRdata_q <= 32'h0000_0000;
      else if (regRd)
         regRdata_q <= rdMux;
      else
         regRdata_q <= 32'h0000_0000;
   end
endmodule // eict_capture_timer
`default_nettype wire

//--- logic/eict_defines.vh
// Register offsets, field positions and encodings of the input capture timer.
`ifndef EICT_DEFINES_VH
`define EICT_DEFINES_VH
`define EICT_ADDR_CNT 8'h00
`define EICT_ADDR_HLD0 8'h04
`define EICT_ADDR_HLD1 8'h08
`define EICT_ADDR_HLD2 8'h0C
`define EICT_ADDR_CMP 8'h10
`define EICT_ADDR_CTL0 8'h14
`define EICT_ADDR_CTL1 8'h18
`define EICT_ADDR_STS 8'h1C
`define EICT_HLD2_RESET 24'h000001
// Main control fields.
`define EICT_C0_BYPASS 3
`define EICT_C0_CHEN_LO 4
`define EICT_C0_SRC_LO 8
`define EICT_C0_CAPIE_LO 16
`define EICT_C0_OVIE 20
`define EICT_C0_CMPIE 21
`define EICT_C0_RUN 24
`define EICT_C0_CLRCMP 25
`define EICT_C0_CLRCAP 26
`define EICT_C0_RELOAD_ENABLE 27
`define EICT_C0_COMPARE_ENABLE 28
`define EICT_C0_UNITEN 29
`define EICT_C0_MASK 32'h3F37_3F78
// Edge and clock control fields.
`define EICT_C1_EDGE_LO 0
`define EICT_C1_RLDS_LO 8
`define EICT_C1_DIV_LO 12
`define EICT_C1_CSRC_LO 16
`define EICT_C1_MASK 32'h0003_773F
// Status fields.
`define EICT_ST_CAPF_LO 0
`define EICT_ST_CMPF 4
`define EICT_ST_OVF 5
`define EICT_ST_LVL_LO 8
// Edge select codes.
`define EICT_EDGE_RISE 2'h0
`define EICT_EDGE_FALL 2'h1
// Filter needs this many equal samples.
`define EICT_FILT_LEN 4
`endif

//--- logic/eict_filter.v
// Four-sample noise filter with bypass and edge detector for one channel.
`timescale 1ns/10ps
`default_nettype none
`include "eict_defines.vh"
module eict_filter #(
   parameter LEN = `EICT_FILT_LEN
) (
   input wire ref_clk,
   input wire resetn,
   input wire sampleIn,
   input wire bypass,
   input wire [1:0] edgeSel,
   output reg level_q,
   output wire edgeHit
);
   reg [LEN-1:0] hist_q;
   reg prevLevel_q;
   wire filtLevel;
   wire allOne;
   wire allZero;
   wire rise;
   wire fall;
   assign allOne = &hist_q;
   assign allZero = ~|hist_q;
   // Level changes only after LEN equal samples of the new value.
   assign filtLevel = allOne ? 1'b1 : (allZero ? 1'b0 : level_q);
   always @(posedge ref_clk) begin
      if (!resetn) begin
         hist_q <= {LEN{1'b0}};
         level_q <= 1'b0;
         prevLevel_q <= 1'b0;
      end else begin
         hist_q <= {hist_q[LEN-2:0], sampleIn};
         level_q <= bypass ? sampleIn : filtLevel;
         prevLevel_q <= level_q;
      end
   end
   assign rise = level_q & ~prevLevel_q;
   assign fall = ~level_q & prevLevel_q;
   assign edgeHit = (edgeSel == `EICT_EDGE_RISE) ? rise :
                    (edgeSel == `EICT_EDGE_FALL) ? fall : (rise | fall);
endmodule // eict_filter
`default_nettype wire

//--- logic/eict_divider.v
// Selectable-source prescaler producing a one-cycle counter tick.
`timescale 1ns/10ps
`default_nettype none
module eict_divider (
   input wire ref_clk,
   input wire resetn,
   input wire [1:0] srcSel,
   input wire [2:0] divSel,
   input wire dedicatedIn,
   input wire chanIn,
   input wire runEn,
   output wire tick
);
   reg [6:0] cnt_q;
   reg srcPrev_q;
   reg [6:0] limit;
   wire srcPulse;
   wire dedEdge;
   always @* begin
      case (divSel)
         3'h0: limit = 7'h00;
         3'h1: limit = 7'h03;
         3'h2: limit = 7'h0F;
         3'h3: limit = 7'h1F;
         3'h4: limit = 7'h3F;
         3'h5: limit = 7'h5F;
         3'h6: limit = 7'h6F;
         default: limit = 7'h7F;
      endcase
   end
   // Slow sources count on their rising edge, the system clock every cycle.
   assign dedEdge = (srcSel == 2'h1) ? dedicatedIn : chanIn;
   assign srcPulse = (srcSel == 2'h0) ? 1'b1 : (dedEdge & ~srcPrev_q);
   always @(posedge ref_clk) begin
      if (!resetn) begin
         cnt_q <= 7'h00;
         srcPrev_q <= 1'b0;
      end else begin
         srcPrev_q <= dedEdge;
         if (!runEn)
            cnt_q <= 7'h00;
         else if (srcPulse)
            cnt_q <= (cnt_q >= limit) ? 7'h00 : cnt_q + 7'h01;
      end
   end
   assign tick = runEn & srcPulse & (cnt_q >= limit);
endmodule // eict_divider
`default_nettype wire

//--- tb/eict_edge_source.sv
// Far-side model driving the capture sources and the dedicated counter clock.
`timescale 1ns/10ps
`default_nettype none
module eict_edge_source (
   input wire logic ref_clk,
   input wire logic [2:0] wantPin,
   input wire logic [2:0] wantCmp,
   input wire logic wantConv,
   output logic [2:0] capturePin,
   output logic [2:0] comparatorCaptureSource,
   output logic converterCompareSource,
   output logic dedicatedCounterClock
);
   initial begin
      capturePin = 3'h0;
      comparatorCaptureSource = 3'h0;
      converterCompareSource = 1'b0;
      dedicatedCounterClock = 1'b0;
   end
   // Sources move just after an edge, like the outputs of synchronous logic.
   always @(posedge ref_clk) begin
      capturePin <= wantPin;
      comparatorCaptureSource <= wantCmp;
      converterCompareSource <= wantConv;
      dedicatedCounterClock <= ~dedicatedCounterClock;
   end
endmodule // eict_edge_source
`default_nettype wire

//--- tb/eict_capture_timer_chk.sv
// Assertions on the register port and interrupt outputs of the capture timer.
`timescale 1ns/10ps
`default_nettype none
`include "eict_defines.vh"
module eict_capture_timer_chk #(
   parameter CW = 24,
   parameter NCH = 3
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   input wire logic [31:0] regRdata_q,
   input wire logic unitInterrupt_q,
   input wire logic matchInterrupt_q,
   input wire logic wrapInterrupt_q
);
   logic [31:0] ctl0_q;
   logic [31:0] ctl1_q;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   // Shadow copies of the control words as software wrote them.
   always @(posedge ref_clk) begin
      if (!resetn) begin
         ctl0_q <= 32'h0;
         ctl1_q <= 32'h0;
      end else if (regWr && regAddr == `EICT_ADDR_CTL0) begin
         ctl0_q <= regWdata & `EICT_C0_MASK;
      end else if (regWr && regAddr == `EICT_ADDR_CTL1) begin
         ctl1_q <= regWdata & `EICT_C1_MASK;
      end
   end
   ctl0_back_a:
      assert property ($past(regRd) && $past(regAddr) == `EICT_ADDR_CTL0
         |-> regRdata_q == $past(ctl0_q)) else $error("Control word 0 read back wrong.");
   ctl1_back_a:
      assert property ($past(regRd) && $past(regAddr) == `EICT_ADDR_CTL1
         |-> regRdata_q == $past(ctl1_q)) else $error("Control word 1 read back wrong.");
   status_unused_a:
      assert property ($past(regRd) && $past(regAddr) == `EICT_ADDR_STS
         |-> (regRdata_q & 32'hFFFF_F8C8) == 32'h0) else $error("Status unused bits set.");
   hold_width_a:
      assert property ($past(regRd) && $past(regAddr) inside {8'h04, 8'h08, 8'h0C}
         |-> regRdata_q[31:24] == 8'h00) else $error("Hold register wider than count.");
   count_width_a:
      assert property ($past(regRd) && $past(regAddr) == `EICT_ADDR_CNT
         |-> regRdata_q[31:24] == 8'h00) else $error("Counter wider than 24 bits.");
   wrap_gate_a:
      assert property (wrapInterrupt_q |-> $past(ctl0_q[20])) else $error("Wrap irq not enabled.");
   match_gate_a:
      assert property (matchInterrupt_q |-> $past(ctl0_q[21])) else $error("Match irq not enabled.");
   irq_off_a:
      assert property (regWr && regAddr == `EICT_ADDR_CTL0 && (regWdata & 32'h0037_0000) == 32'h0
         |-> ##2 !unitInterrupt_q) else $error("Interrupt stays with all enables clear.");
   cover property (matchInterrupt_q);
   cover property (wrapInterrupt_q);
   cover property ($rose(unitInterrupt_q));
endmodule // eict_capture_timer_chk
bind eict_capture_timer eict_capture_timer_chk #(.CW(CW), .NCH(NCH)) u_chk (.ref_clk(ref_clk),
   .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
   .regRdata_q(regRdata_q), .unitInterrupt_q(unitInterrupt_q),
   .matchInterrupt_q(matchInterrupt_q), .wrapInterrupt_q(wrapInterrupt_q));
`default_nettype wire

//--- tb/enhanced_input_capture_timer_test.sv
// Self-checking bench of the capture timer against a behavioural register model.
`timescale 1ns/10ps
`default_nettype none
`include "eict_defines.vh"
module enhanced_input_capture_timer_test;
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic [7:0] regAddr = 8'h00;
   logic [31:0] regWdata = 32'h0;
   logic [2:0] wantPin = 3'h0;
   logic [2:0] wantCmp = 3'h0;
   logic wantConv = 1'b0;
   logic [31:0] regRdata_q, rv;
   logic [2:0] capturePin, comparatorCaptureSource, lvl;
   logic converterCompareSource, dedicatedCounterClock;
   logic unitInterrupt_q, matchInterrupt_q, wrapInterrupt_q;
   int miscompares = 0;
   int nTests = 0;
   int mdl[8];
   int divs[9] = '{1, 4, 16, 32, 64, 96, 112, 128, 8};
   int plen[3] = '{3, 7, 2};
   int i, k;
   eict_capture_timer u_eict_capture_timer (.ref_clk(ref_clk), .resetn(resetn),
      .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
      .regRdata_q(regRdata_q), .capturePin(capturePin),
      .comparatorCaptureSource(comparatorCaptureSource),
      .converterCompareSource(converterCompareSource),
      .dedicatedCounterClock(dedicatedCounterClock), .unitInterrupt_q(unitInterrupt_q),
      .matchInterrupt_q(matchInterrupt_q), .wrapInterrupt_q(wrapInterrupt_q));
   eict_edge_source u_eict_edge_source (.ref_clk(ref_clk), .wantPin(wantPin),
      .wantCmp(wantCmp), .wantConv(wantConv), .capturePin(capturePin),
      .comparatorCaptureSource(comparatorCaptureSource),
      .converterCompareSource(converterCompareSource),
      .dedicatedCounterClock(dedicatedCounterClock));
   initial begin
      forever #5 ref_clk = ~ref_clk;
   end
   // ==========
   // Bus tasks, model and comparisons.
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      nTests++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chkRange(input string what, input int lo, input int hi, input logic [31:0] got);
      nTests++;
      if ((^got === 1'bx) || got < lo || got > hi) begin
         miscompares++;
         $display("ERROR %s expected %0d to %0d seen %h", what, lo, hi, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge ref_clk);
      regWr <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge ref_clk);
      regRd <= 1'b0;
      @(negedge ref_clk);
      v = regRdata_q;
      @(posedge ref_clk);
   endtask
   task automatic wm(input logic [7:0] a, input logic [31:0] d);
      wr(a, d);
      case (a)
         `EICT_ADDR_CTL0: mdl[5] = d & `EICT_C0_MASK;
         `EICT_ADDR_CTL1: mdl[6] = d & `EICT_C1_MASK;
         `EICT_ADDR_STS: mdl[7] &= ~(d & 32'h37);
         default: mdl[a >> 2] = d & 32'hFF_FFFF;
      endcase
   endtask
   task automatic rdAll();
      for (int j = 0; j < 8; j++) begin
         rd(8'(4 * j), rv);
         chk($sformatf("register %0d", j), j == 7 ? mdl[7] | {21'h0, lvl, 8'h00} : mdl[j], rv);
      end
   endtask
   function automatic logic srcVal(int ch);
      case ((mdl[5] >> (8 + 2 * ch)) & 3)
         0: return wantPin[ch];
         1: return wantCmp[ch];
         default: return wantConv;
      endcase
   endfunction
   task automatic eval();
      int cnt;
      int e;
      cnt = mdl[0];
      for (int ch = 0; ch < 3; ch++) begin
         if (srcVal(ch) != lvl[ch]) begin
            lvl[ch] = srcVal(ch);
            e = (mdl[6] >> (2 * ch)) & 3;
            if (mdl[5][29] && mdl[5][4 + ch] && (lvl[ch] ? e != 1 : e != 0)) begin
               mdl[1 + ch] = cnt;
               mdl[7][ch] = 1'b1;
               if (mdl[5][27] && mdl[6][9 + ch]) begin
                  mdl[0] = mdl[4];
               end else if (mdl[5][26] && !mdl[5][27]) begin
                  mdl[0] = 0;
               end
            end
         end
      end
   endtask
   task automatic settle();
      repeat (12) @(posedge ref_clk);
      eval();
      chk("unitInterrupt", {31'h0, |(mdl[7][2:0] & mdl[5][18:16])}, {31'h0, unitInterrupt_q});
   endtask
   task automatic complete_run();
      $display("Comparisons %0d mismatches %0d", nTests, miscompares);
      if (miscompares == 0 && nTests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // ==========
   // Scenarios.
   initial begin
      void'($urandom(32'hC358));
      mdl = '{default: 0};
      mdl[3] = 1;
      lvl = 3'h0;
      repeat (6) @(posedge ref_clk);
      resetn <= 1'b1;
      @(posedge ref_clk);
      rdAll();
      rd(8'h20, rv);
      chk("unmapped", 32'h0, rv);
      wr(8'h24, 32'hFFFF_FFFF);
      wm(`EICT_ADDR_CMP, $urandom());
      wm(`EICT_ADDR_HLD0, $urandom());
      rdAll();
      for (i = 0; i < 24; i++) begin
         wm(`EICT_ADDR_CNT, $urandom());
         wm(`EICT_ADDR_CTL1, $urandom());
         wm(`EICT_ADDR_CTL0, ($urandom() & 32'h0C07_3F78) | 32'h2000_0000);
         settle();
         wantPin <= 3'($urandom());
         wantCmp <= 3'($urandom());
         wantConv <= 1'($urandom());
         settle();
         rdAll();
         wm(`EICT_ADDR_STS, $urandom());
      end
      wm(`EICT_ADDR_CTL1, 32'h0000_002A);
      for (k = 0; k < 3; k++) begin
         wm(`EICT_ADDR_CTL0, k == 2 ? 32'h2007_0078 : 32'h2007_0070);
         settle();
         wm(`EICT_ADDR_STS, 32'h37);
         wm(`EICT_ADDR_CNT, $urandom());
         wantPin <= ~wantPin;
         repeat (plen[k]) @(posedge ref_clk);
         if (k > 0) eval();
         wantPin <= ~wantPin;
         settle();
         rdAll();
      end
      for (k = 0; k < 9; k++) begin
         wm(`EICT_ADDR_CTL1, k < 8 ? k << 12 : 32'h0001_1000);
         wm(`EICT_ADDR_CNT, 32'h0);
         wm(`EICT_ADDR_CTL0, 32'h2100_0000);
         repeat (512) @(posedge ref_clk);
         wm(`EICT_ADDR_CTL0, 32'h2000_0000);
         rd(`EICT_ADDR_CNT, rv);
         chkRange("counter", 513 / divs[k] - 2, 513 / divs[k] + 2, rv);
      end
      wm(`EICT_ADDR_CTL1, 32'h0);
      wm(`EICT_ADDR_CMP, 32'h40);
      wm(`EICT_ADDR_CNT, 32'h0);
      wm(`EICT_ADDR_CTL0, 32'h3320_0000);
      for (k = 0; k < 200 && matchInterrupt_q !== 1'b1; k++) @(posedge ref_clk);
      chk("matchInterrupt", 32'h1, {31'h0, matchInterrupt_q});
      for (k = 0; k < 4; k++) begin
         rd(`EICT_ADDR_CNT, rv);
         chkRange("counter", 0, 65, rv);
      end
      wm(`EICT_ADDR_CTL1, 32'h100);
      wm(`EICT_ADDR_CMP, 32'h100);
      wm(`EICT_ADDR_CNT, 32'hFF_FFF0);
      wm(`EICT_ADDR_CTL0, 32'h2910_0000);
      for (k = 0; k < 200 && wrapInterrupt_q !== 1'b1; k++) @(posedge ref_clk);
      chk("wrapInterrupt", 32'h1, {31'h0, wrapInterrupt_q});
      rd(`EICT_ADDR_CNT, rv);
      chkRange("counter", 256, 320, rv);
      wm(`EICT_ADDR_CTL0, 32'h2000_0000);
      rd(`EICT_ADDR_STS, rv);
      chk("flags", 32'h30, rv & 32'h30);
      wm(`EICT_ADDR_STS, 32'h37);
      rd(`EICT_ADDR_STS, rv);
      chk("flags", 32'h0, rv & 32'h37);
      wm(`EICT_ADDR_CTL0, 32'h0007_0078);
      wantPin <= ~wantPin;
      repeat (12) @(posedge ref_clk);
      rd(`EICT_ADDR_STS, rv);
      chk("flags", 32'h0, rv & 32'h37);
      complete_run();
   end
   initial begin
      repeat (20000) @(posedge ref_clk);
      miscompares++;
      complete_run();
   end
endmodule // enhanced_input_capture_timer_test
`default_nettype wire
